// *** rtl/port_switch_matrix_gpio.sv ***
// Purpose: Priority switch matrix plus general-purpose port data register
// Assumes: One system clock, synchronous active-low reset
// Notes:   Pin inputs are synchronised; all outputs are registered
`timescale 1ns/1ps
`include "port_switch_matrix_gpio_defs.svh"

module port_switch_matrix_gpio (
  input  wire logic                           ref_clk_in,
  input  wire logic                           reset_n_in,
  // Special function register access
  input  wire logic [7:0]                     sfr_addr_in,
  input  wire logic                           sfr_wr_in,
  input  wire logic                           sfr_rd_in,
  input  wire logic                           sfr_rmw_in,
  input  wire logic                           sfr_bit_in,
  input  wire logic [2:0]                     sfr_bit_sel_in,
  input  wire logic [7:0]                     sfr_wdata_in,
  output logic      [7:0]                     sfr_rdata_out,
  // Output mode per pin, 1 = push-pull, 0 = open-drain
  input  wire logic [`PORT_W-1:0]             port_drive_mode_in,
  // Peripheral side, indexed by port_switch_matrix_gpio_pkg::route_fn_t
  input  wire logic [`FN_COUNT-1:0]           periph_drive_in,
  output logic      [`FN_COUNT-1:0]           periph_sense_out,
  // Pin side
  input  wire logic [`PORT_W-1:0]             pin_in,
  output logic      [`PORT_W-1:0]             pin_out,
  output logic      [`PORT_W-1:0]             pin_oe_out,
  output logic      [`PORT_W-1:0]             pin_pullup_out,
  output port_switch_matrix_gpio_pkg::route_fn_t pin_fn_out [`PORT_W]
);
  import port_switch_matrix_gpio_pkg::*;

  // Registers seen by software
  // Middle bits of control b are masked on both write and read
  logic [7:0]  port0_data_ff;             // Output latch
  logic [7:0]  nxt_port0_data;
  logic [7:0]  route_a_ff;                // switch_route_ctrl_a
  logic [7:0]  nxt_route_a;
  logic [7:0]  route_b_ff;                // switch_route_ctrl_b
  logic [7:0]  nxt_route_b;
  logic [7:0]  rdata_ff;                  // Read data holder
  logic [7:0]  nxt_rdata;

  // Pin synchroniser; stage one is read only by stage two
  logic [`PORT_W-1:0] pin_meta_ff;
  logic [`PORT_W-1:0] pin_sync_ff;

  // Registered pin side and peripheral side
  logic [`PORT_W-1:0]   pin_out_ff;
  logic [`PORT_W-1:0]   nxt_pin_out;
  logic [`PORT_W-1:0]   pin_oe_ff;
  logic [`PORT_W-1:0]   nxt_pin_oe;
  logic [`PORT_W-1:0]   pin_pu_ff;
  logic [`PORT_W-1:0]   nxt_pin_pu;
  logic [`FN_COUNT-1:0] sense_ff;
  logic [`FN_COUNT-1:0] nxt_sense;
  route_fn_t            pin_fn_ff  [`PORT_W];
  route_fn_t            nxt_pin_fn [`PORT_W];

  // Decoded requests, one bit per route_fn_t entry except fn_none
  logic [`FN_COUNT-1:0] req;

  // True for functions the pin only feeds, never drives
  function automatic logic is_input_fn(input route_fn_t f);
    return (f == fn_serial_rx) || (f == fn_ext_count) ||
           (f == fn_tmr0_in)   || (f == fn_tmr1_in);
  endfunction

  // Two-wire pins are open-drain whatever the mode register says
  function automatic logic is_two_wire(input route_fn_t f);
    return (f == fn_two_wire_sda) || (f == fn_two_wire_scl);
  endfunction

  // Address compare shared by read and write paths
  // Unmapped addresses fall through to the zero answer
  function automatic logic hit(input logic [7:0] a,
                               input logic [7:0] ref_a);
    return a == ref_a;
  endfunction

  // Synchroniser for the asynchronous pin levels
  // Reset value is harmless: it is gone two edges after release
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_in;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  // Register write and read decode
  // A write and a read in one cycle are allowed; the read
  // returns the value held before the write lands
  always_comb begin
    nxt_port0_data = port0_data_ff;
    nxt_route_a    = route_a_ff;
    nxt_route_b    = route_b_ff;
    nxt_rdata      = rdata_ff;
    if (sfr_wr_in) begin
      if (hit(sfr_addr_in, `ADDR_PORT0_DATA)) begin
        if (sfr_bit_in) begin
          // Single bit write leaves the other latch bits alone
          nxt_port0_data[sfr_bit_sel_in] = sfr_wdata_in[0];
        end else begin
          nxt_port0_data = sfr_wdata_in;
        end
      end else if (hit(sfr_addr_in, `ADDR_ROUTE_CTRL_A)) begin
        nxt_route_a = sfr_wdata_in;
      end else if (hit(sfr_addr_in, `ADDR_ROUTE_CTRL_B)) begin
        // Unused middle bits are never stored
        nxt_route_b = sfr_wdata_in & `MASK_CTRL_B;
      end
    end
    if (sfr_rd_in) begin
      if (hit(sfr_addr_in, `ADDR_PORT0_DATA)) begin
        // Read-modify-write must see the latch, else pin levels
        // of peripherals would leak into the written-back value
        nxt_rdata = sfr_rmw_in ? port0_data_ff
                               : pin_sync_ff;
        if (sfr_bit_in) begin
          nxt_rdata = {7'h00, nxt_rdata[sfr_bit_sel_in]};
        end
      end else if (hit(sfr_addr_in, `ADDR_ROUTE_CTRL_A)) begin
        nxt_rdata = route_a_ff;
      end else if (hit(sfr_addr_in, `ADDR_ROUTE_CTRL_B)) begin
        nxt_rdata = route_b_ff & `MASK_CTRL_B;
      end else begin
        // Unknown address answers zero
        nxt_rdata = 8'h00;
      end
    end
  end

  // Register storage
  // Read data holds until the next read strobe
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      port0_data_ff <= `RST_PORT0_DATA;
      route_a_ff    <= `RST_ROUTE_CTRL_A;
      route_b_ff    <= `RST_ROUTE_CTRL_B;
      rdata_ff      <= 8'h00;
    end else begin
      port0_data_ff <= nxt_port0_data;
      route_a_ff    <= nxt_route_a;
      route_b_ff    <= nxt_route_b;
      rdata_ff      <= nxt_rdata;
    end
  end

  // Decode the enable fields into one request per function
  // Requests stand even with the matrix off; placement gates them
  always_comb begin
    req = '0;
    req[fn_serial_tx]    = route_a_ff[`BIT_SERIAL_TX];
    req[fn_serial_rx]    = route_a_ff[`BIT_SERIAL_RX];
    req[fn_two_wire_sda] = route_a_ff[`BIT_TWO_WIRE];
    req[fn_two_wire_scl] = route_a_ff[`BIT_TWO_WIRE];
    req[fn_cmp_sync]     = route_a_ff[`BIT_CMP_SYNC];
    req[fn_cmp_async]    = route_a_ff[`BIT_CMP_ASYNC];
    req[fn_sysclk]       = route_a_ff[`BIT_SYSCLK];
    // Channel count: 00 none, 01 ch0, 10 ch0-1, 11 ch0-2
    req[fn_ta_ch0] = |route_a_ff[`TA_SEL_HI:`TA_SEL_LO];
    req[fn_ta_ch1] = route_a_ff[`TA_SEL_HI];
    req[fn_ta_ch2] = &route_a_ff[`TA_SEL_HI:`TA_SEL_LO];
    req[fn_ext_count] = route_b_ff[`BIT_EXT_COUNT];
    req[fn_tmr0_in]   = route_b_ff[`BIT_TMR0_IN];
    req[fn_tmr1_in]   = route_b_ff[`BIT_TMR1_IN];
  end

  // Priority assignment of functions to pins
  // Serial pins are pinned first, then the rest fill the lowest
  // free pin in priority order; requests past pin 7 are dropped
  // Loops have constant bounds, so the search unrolls into
  // a fixed priority encoder per pin
  always_comb begin
    logic placed;
    placed = 1'b0;
    for (int p = 0; p < `PORT_W; p++) begin
      nxt_pin_fn[p] = fn_none;
    end
    if (req[fn_serial_tx]) begin
      nxt_pin_fn[`PIN_SERIAL_TX] = fn_serial_tx;
    end
    if (req[fn_serial_rx]) begin
      nxt_pin_fn[`PIN_SERIAL_RX] = fn_serial_rx;
    end
    for (int f = 2; f < `FN_COUNT; f++) begin
      placed = 1'b0;
      for (int p = 0; p < `PORT_W; p++) begin
        if (req[f] && !placed && nxt_pin_fn[p] == fn_none &&
            !(req[fn_serial_tx] && p == `PIN_SERIAL_TX) &&
            !(req[fn_serial_rx] && p == `PIN_SERIAL_RX)) begin
          nxt_pin_fn[p] = route_fn_t'(f);
          placed        = 1'b1;
        end
      end
    end
    // With the matrix off nothing is claimed
    if (!route_b_ff[`BIT_MATRIX_EN]) begin
      for (int p = 0; p < `PORT_W; p++) begin
        nxt_pin_fn[p] = fn_none;
      end
    end
  end

  // Pin drive, enable and pull-up per pin
  // A routed function replaces the latch on its pin only; the
  // latch keeps its value for when the route is dropped again
  always_comb begin
    logic lvl;
    logic od;
    lvl = 1'b1;
    od  = 1'b1;
    for (int p = 0; p < `PORT_W; p++) begin
      // Level comes from the function or from the latch
      if (nxt_pin_fn[p] == fn_none) begin
        lvl = port0_data_ff[p];
      end else begin
        lvl = periph_drive_in[nxt_pin_fn[p]];
      end
      od = !port_drive_mode_in[p] || is_two_wire(nxt_pin_fn[p]);
      nxt_pin_out[p] = lvl;
      if (!route_b_ff[`BIT_MATRIX_EN]) begin
        nxt_pin_oe[p] = 1'b0;
      end else if (is_input_fn(nxt_pin_fn[p])) begin
        // Input functions leave the driver off
        nxt_pin_oe[p] = 1'b0;
      end else begin
        // Open-drain drives only the zero level
        nxt_pin_oe[p] = od ? !lvl : 1'b1;
      end
      // Pull-up only on open-drain pins not pulling low,
      // which avoids burning current against our own driver
      nxt_pin_pu[p] = !route_b_ff[`BIT_WEAK_PU_DIS] && od &&
                      !nxt_pin_oe[p];
    end
  end

  // Peripheral inputs see their pin; unrouted ones idle high
  // High matches a released open-drain line, so an unrouted
  // receiver never sees a false start
  always_comb begin
    nxt_sense = '1;
    for (int p = 0; p < `PORT_W; p++) begin
      if (nxt_pin_fn[p] != fn_none) begin
        nxt_sense[nxt_pin_fn[p]] = pin_sync_ff[p];
      end
    end
  end

  // Pin and peripheral side registers
  // Reset leaves every pin an undriven input
  always_ff @(posedge ref_clk_in) begin
    if (!reset_n_in) begin
      pin_out_ff <= '1;
      pin_oe_ff  <= '0;
      pin_pu_ff  <= '0;
      sense_ff   <= '1;
      for (int p = 0; p < `PORT_W; p++) begin
        pin_fn_ff[p] <= fn_none;
      end
    end else begin
      pin_out_ff <= nxt_pin_out;
      pin_oe_ff  <= nxt_pin_oe;
      pin_pu_ff  <= nxt_pin_pu;
      sense_ff   <= nxt_sense;
      for (int p = 0; p < `PORT_W; p++) begin
        pin_fn_ff[p] <= nxt_pin_fn[p];
      end
    end
  end

  // Outputs straight from flops
  // The function map lets the system see the matrix result
  assign sfr_rdata_out    = rdata_ff;
  assign pin_out          = pin_out_ff;
  assign pin_oe_out       = pin_oe_ff;
  assign pin_pullup_out   = pin_pu_ff;
  assign periph_sense_out = sense_ff;
  assign pin_fn_out       = pin_fn_ff;
endmodule

// *** common/port_switch_matrix_gpio_defs.svh ***
// Purpose: Offsets, field positions, reset values for the port matrix
// Assumes: Eight-bit special function register space
// Notes:   Included by the design file only
`ifndef PORT_SWITCH_MATRIX_GPIO_DEFS_SVH
`define PORT_SWITCH_MATRIX_GPIO_DEFS_SVH

// Register addresses
`define ADDR_PORT0_DATA     8'h80
`define ADDR_ROUTE_CTRL_A   8'he2
`define ADDR_ROUTE_CTRL_B   8'he3

// Reset values (port latch idles high so pins float released)
`define RST_PORT0_DATA      8'hff
`define RST_ROUTE_CTRL_A    8'h00
`define RST_ROUTE_CTRL_B    8'h00

// Fields of switch_route_ctrl_a
`define TA_SEL_HI           7
`define TA_SEL_LO           6
`define BIT_CMP_ASYNC       5
`define BIT_CMP_SYNC        4
`define BIT_SYSCLK          3
`define BIT_TWO_WIRE        2
`define BIT_SERIAL_RX       1
`define BIT_SERIAL_TX       0

// Fields of switch_route_ctrl_b
`define BIT_WEAK_PU_DIS     7
`define BIT_MATRIX_EN       6
`define MASK_CTRL_B         8'hc7
`define BIT_TMR1_IN         2
`define BIT_TMR0_IN         1
`define BIT_EXT_COUNT       0

// Fixed pins of the serial port
`define PIN_SERIAL_TX       3'h4
`define PIN_SERIAL_RX       3'h5

// Port width and number of routable functions
`define PORT_W              8
`define FN_COUNT            13
`endif

// *** common/port_switch_matrix_gpio_pkg.sv ***
// Purpose: Types shared by the port matrix and its bench
// Assumes: Nothing
// Notes:   Order of the enum is the matrix priority order
package port_switch_matrix_gpio_pkg;
  // Routable functions, highest priority first; fn_none = plain port bit
  typedef enum logic [3:0] {
    fn_serial_tx,
    fn_serial_rx,
    fn_two_wire_sda,
    fn_two_wire_scl,
    fn_cmp_sync,
    fn_cmp_async,
    fn_sysclk,
    fn_ta_ch0,
    fn_ta_ch1,
    fn_ta_ch2,
    fn_ext_count,
    fn_tmr0_in,
    fn_tmr1_in,
    fn_none
  } route_fn_t;
endpackage

// *** testbench/port_switch_matrix_gpio_props.sv ***
// Purpose: Assertions on the port matrix top-level ports
// Assumes: Pin outputs follow a route write after two edges
// Notes:   Route registers are shadowed from observed writes
`timescale 1ns/1ps
module port_switch_matrix_gpio_props (
  input logic                                   ref_clk_in,
  input logic                                   reset_n_in,
  input logic [7:0]                             sfr_addr_in,
  input logic                                   sfr_wr_in,
  input logic                                   sfr_rd_in,
  input logic                                   sfr_rmw_in,
  input logic                                   sfr_bit_in,
  input logic [7:0]                             sfr_wdata_in,
  input logic [7:0]                             sfr_rdata_out,
  input logic [7:0]                             port_drive_mode_in,
  input logic [7:0]                             pin_oe_out,
  input logic [7:0]                             pin_pullup_out,
  input port_switch_matrix_gpio_pkg::route_fn_t pin_fn_out [8]
);
  import port_switch_matrix_gpio_pkg::*;
  logic [7:0]  a_sh_ff, nxt_a_sh;  // Shadow of route control a
  logic [1:0]  b_sh_ff, nxt_b_sh;  // Shadow of pull-up disable and enable
  logic [15:0] fn_seen;            // Functions that own some pin
  logic        wr_p, rd_l;         // Byte write, latch read of the port
  // Shadow is needed because the route registers are not on the ports
  always_comb begin
    nxt_a_sh = (sfr_wr_in && sfr_addr_in == 8'he2) ? sfr_wdata_in : a_sh_ff;
    nxt_b_sh = (sfr_wr_in && sfr_addr_in == 8'he3) ? sfr_wdata_in[7:6] : b_sh_ff;
    wr_p = sfr_wr_in && !sfr_bit_in && sfr_addr_in == 8'h80;
    rd_l = sfr_rd_in && sfr_rmw_in && !sfr_bit_in && sfr_addr_in == 8'h80;
    fn_seen = '0;
    for (int i = 0; i < 8; i++) begin
      fn_seen[pin_fn_out[i]] = 1'b1;
    end
  end
  // Register the shadow, cleared by reset like the block
  always_ff @(posedge ref_clk_in) begin
    a_sh_ff <= reset_n_in ? nxt_a_sh : 8'h00;
    b_sh_ff <= reset_n_in ? nxt_b_sh : 2'h0;
  end
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  a_matrix_off: assert property (!$past(b_sh_ff[0]) |->
    pin_oe_out == 8'h00 && fn_seen == 16'h2000) else $error("pin driven while matrix off");
  a_tx_fixed: assert property ($past(b_sh_ff[0] && a_sh_ff[0]) |->
    pin_fn_out[4] == fn_serial_tx) else $error("transmit not on pin 4");
  a_rx_fixed: assert property ($past(b_sh_ff[0] && a_sh_ff[1]) |->
    pin_fn_out[5] == fn_serial_rx && !pin_oe_out[5]) else $error("receive not on pin 5");
  a_pullup_rule: assert property ($past(reset_n_in) && !$past(b_sh_ff[0]) |->
    pin_pullup_out == ({8{!$past(b_sh_ff[1])}} & ~$past(port_drive_mode_in)))
    else $error("pull-up wrong");
  a_ta_sel: assert property ($past(a_sh_ff[7:6]) != 2'b11 |-> !fn_seen[fn_ta_ch2])
    else $error("channel 2 routed unasked");
  a_two_wire: assert property (!$past(a_sh_ff[2]) |->
    !fn_seen[fn_two_wire_sda] && !fn_seen[fn_two_wire_scl]) else $error("two-wire routed");
  a_sysclk_gate: assert property (!$past(a_sh_ff[3]) |-> !fn_seen[fn_sysclk])
    else $error("clock routed unasked");
  a_cmp_gate: assert property (!$past(a_sh_ff[5]) |-> !fn_seen[fn_cmp_async])
    else $error("comparator routed unasked");
  a_unused_zero: assert property (sfr_rd_in && sfr_addr_in == 8'he3 && !sfr_bit_in
    |=> sfr_rdata_out[5:3] == 3'h0) else $error("unused bits read nonzero");
  a_rmw_latch: assert property (rd_l && $past(wr_p && reset_n_in, 2) &&
    !$past(sfr_wr_in && sfr_addr_in == 8'h80) && $past(reset_n_in)
    |=> sfr_rdata_out == $past(sfr_wdata_in, 3)) else $error("latch read wrong");
endmodule
bind port_switch_matrix_gpio port_switch_matrix_gpio_props u_props (.ref_clk_in, .reset_n_in,
  .sfr_addr_in, .sfr_wr_in, .sfr_rd_in, .sfr_rmw_in, .sfr_bit_in, .sfr_wdata_in,
  .sfr_rdata_out, .port_drive_mode_in, .pin_oe_out, .pin_pullup_out, .pin_fn_out);

// *** testbench/port_pin_world.sv ***
// Purpose: Level on each package pin as seen from outside
// Assumes: Outside drivers only act where the block is not driving
// Notes:   Floating pins toggle so no stale level can pass a check
`timescale 1ns/1ps
module port_pin_world (
  input  logic       ref_clk_in,
  input  logic [7:0] drive_in,
  input  logic [7:0] oe_in,
  input  logic [7:0] pullup_in,
  input  logic [7:0] ext_en_in,
  input  logic [7:0] ext_val_in,
  output logic [7:0] level_out
);
  logic [7:0] float_ff = 8'h55;  // Changes every cycle on floating pins
  // Toggle pattern for unpulled, undriven pins
  always_ff @(posedge ref_clk_in) begin
    float_ff <= ~float_ff;
  end
  // Block drive wins, then the outside, then the weak pull-up
  always_comb begin
    level_out = (oe_in & drive_in) | (~oe_in & ext_en_in & ext_val_in)
              | (~oe_in & ~ext_en_in & (pullup_in | float_ff));
  end
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the port switch matrix
// Assumes: Inputs change on the falling clock edge
// Notes:   Expected values come from route and port behaviour
`timescale 1ns/1ps
module testbench;
  import port_switch_matrix_gpio_pkg::*;
  logic        clk = 0, rst_n = 0, wr = 0, rd = 0, rmw = 0, bsel = 0;
  logic [7:0]  addr = 0, wdata = 0, mode = 0, ext_en = 0, ext_val = 0;
  logic [2:0]  sel = 0;
  logic [12:0] pdrv = 0, sense;
  logic [7:0]  rdata, pout, poe, ppu, lvl;
  route_fn_t   pfn [8];
  int          n_fail = 0, check_count = 0;
  // Route table: control a value, owning pin and expected function
  logic [7:0]  ra [13] = '{8'h01, 8'h02, 8'h04, 8'h04, 8'h10, 8'h20, 8'h08, 8'h40, 8'hc0,
                           8'h80, 8'h00, 8'h00, 8'h00};
  logic [2:0]  rp [13] = '{3'h4, 3'h5, 3'h0, 3'h1, 3'h0, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h0,
                           3'h0, 3'h0};
  route_fn_t   rf [13] = '{fn_serial_tx, fn_serial_rx, fn_two_wire_sda, fn_two_wire_scl,
                           fn_cmp_sync, fn_cmp_async, fn_sysclk, fn_ta_ch0, fn_ta_ch2,
                           fn_ta_ch1, fn_ext_count, fn_tmr0_in, fn_tmr1_in};
  port_switch_matrix_gpio u_dut (
    .ref_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr), .sfr_wr_in(wr),
    .sfr_rd_in(rd), .sfr_rmw_in(rmw), .sfr_bit_in(bsel), .sfr_bit_sel_in(sel),
    .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .port_drive_mode_in(mode),
    .periph_drive_in(pdrv), .periph_sense_out(sense), .pin_in(lvl), .pin_out(pout),
    .pin_oe_out(poe), .pin_pullup_out(ppu), .pin_fn_out(pfn));
  port_pin_world u_pins (.ref_clk_in(clk), .drive_in(pout), .oe_in(poe), .pullup_in(ppu),
    .ext_en_in(ext_en), .ext_val_in(ext_val), .level_out(lvl));
  always #5 clk = ~clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One-cycle write strobe, byte or bit access
  task automatic wr_reg(input logic [7:0] a, d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(negedge clk);
    {addr, wdata, wr, bsel, sel} = {a, d, 1'b1, b, s};
    @(negedge clk);
    {wr, bsel} = 2'b00;
  endtask
  // Read strobe, data is taken one edge later
  task automatic chk_rd(input logic [7:0] a, input logic m, b, input logic [2:0] s,
                        input logic [7:0] e);
    @(negedge clk);
    {addr, rd, rmw, bsel, sel} = {a, 1'b1, m, b, s};
    @(negedge clk);
    {rd, rmw, bsel} = 3'b000;
    chk(rdata, e);
  endtask
  task automatic t_regs();
    chk_rd(8'he2, 1'b0, 1'b0, 3'h0, 8'h00);
    chk_rd(8'he3, 1'b0, 1'b0, 3'h0, 8'h00);
    wr_reg(8'he3, 8'hff);
    chk_rd(8'he3, 1'b0, 1'b0, 3'h0, 8'hc7);
    wr_reg(8'he3, 8'h00);
    wr_reg(8'h10, 8'hff);
    chk_rd(8'h10, 1'b0, 1'b0, 3'h0, 8'h00);
  endtask
  // Latch against pin reads, byte and bit accesses
  task automatic t_port();
    {ext_en, ext_val} = 16'hff3c;
    wr_reg(8'h80, 8'ha5);
    chk_rd(8'h80, 1'b1, 1'b0, 3'h0, 8'ha5);
    idle(3);
    chk_rd(8'h80, 1'b0, 1'b0, 3'h0, 8'h3c);
    wr_reg(8'h80, 8'h00, 1'b1, 3'h0);
    chk_rd(8'h80, 1'b1, 1'b1, 3'h2, 8'h01);
    chk_rd(8'h80, 1'b1, 1'b0, 3'h0, 8'ha4);
    ext_en = 8'h00;
  endtask
  // Every route choice lands on its pin; receive level reaches its sense
  task automatic t_routes();
    pdrv = '1;
    for (int i = 0; i < 13; i++) begin
      wr_reg(8'he2, ra[i]);
      wr_reg(8'he3, i < 10 ? 8'h40 : 8'h40 | (8'h01 << (i - 10)));
      idle(1);
      chk(pfn[rp[i]], rf[i]);
      if (i != 1 && i < 10) begin
        chk(pout[rp[i]], 1'b1);
      end
    end
    wr_reg(8'he2, 8'h02);
    {ext_en, ext_val} = 16'h2000;
    idle(4);
    chk(sense[fn_serial_rx], 1'b0);
    ext_val = 8'h20;
    idle(4);
    chk(sense[fn_serial_rx], 1'b1);
    wr_reg(8'he3, 8'h00);
    idle(1);
    chk(poe, 8'h00);
    ext_en = 8'h00;
  endtask
  // Plain port bits in both drive modes, then pull-ups disabled
  task automatic t_gpio();
    wr_reg(8'he2, 8'h00);
    wr_reg(8'he3, 8'h40);
    mode = 8'hff;
    wr_reg(8'h80, 8'h5a);
    idle(1);
    chk({poe, pout}, 16'hff5a);
    mode = 8'h00;
    idle(2);
    chk({poe, ppu}, 16'ha55a);
    chk(lvl, 8'h5a);
    wr_reg(8'he3, 8'hc0);
    idle(1);
    chk(ppu, 8'h00);
  endtask
  task automatic conclude();
    if (n_fail == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_fail++;
    conclude();
  end
  initial begin
    repeat (8) @(negedge clk);
    rst_n = 1;
    t_regs();
    t_port();
    t_routes();
    t_gpio();
    rst_n = 0;
    idle(3);
    rst_n = 1;
    chk_rd(8'he3, 1'b0, 1'b0, 3'h0, 8'h00);
    conclude();
  end
endmodule
